// >>> common/bdfs_pkg.sv
// Constants and state encoding for the buck drive fault sequencer
// Operation
// RULE1: Soft-start keeps low-side off until first high-side pulse, then complements high-side.
// RULE2: Normal mode turns low-side off at cycle start, on when high-side ends.
// RULE3: Overvoltage keeps low-side on; off at cycle start only for nonzero duty.
// RULE4: Modulator never starts unless the ramp reached about 1 V within one cycle.
// RULE5: Start at programmed supply level; stop below a level 20% lower.
// RULE6: Start-up regulates to lower of shifted ramp or 700 mV; then reference only.
// RULE7: Overcurrent ends the pulse at once; high-side stays off until next cycle.
// RULE8: Pull limit sense node down before turn-on; release on switch rise or timeout.
// RULE9: Overcurrent detection is blanked from turn-on until the sense node is released.
// RULE10: Fault counter increments per overcurrent cycle, decrements per clean cycle.
// RULE11: Counter reaching 7 declares a fault and turns both gate drives off.
// RULE12: Fault runs seven soft-start cycles with gates idle and modulator disabled.
// RULE13: In hiccup decrement once per soft-start cycle; at zero restart normally.
// RULE14: Persisting overcurrent after restart counts seven pulses and re-enters hiccup.
// RULE15: Soft-start node below 250 mV shuts down with both gate drives low.
// RULE16: Fault counter saturates at zero and never goes below it.
package bdfs_pkg;
  localparam int CLK_MHZ = 200;
  // Sense release timeout, longest time, so cycles round down
  localparam int BLANK_TIMEOUT_NS = 200;
  localparam int BLANK_CYC = (BLANK_TIMEOUT_NS * CLK_MHZ) / 1000;
  localparam logic [7:0] BLANK_CYC_W = BLANK_CYC[7:0];
  localparam logic [2:0] FAULT_LIMIT = 3'h7;
  localparam logic [2:0] FAULT_ZERO = 3'h0;
  localparam int NUM_PINS = 10;
  // Pin vector positions
  localparam int P_START = 0;
  localparam int P_STOP = 1;
  localparam int P_SS_LOW = 2;
  localparam int P_RAMP = 3;
  localparam int P_LIMIT_SENSE_NODE = 4;
  localparam int P_SWHI = 5;
  localparam int P_PWMEND = 6;
  localparam int P_SSREF = 7;
  localparam int P_OVP = 8;
  localparam int P_SSDONE = 9;
  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_SOFT = 3'b001,
    ST_NORM = 3'b010,
    ST_OVP = 3'b011,
    ST_HICCUP = 3'b100
  } bdfs_state_t;
endpackage

// >>> src/bdfs_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module bdfs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] stable_out
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] stable_next;

  // Each bit updates only when stages two and three agree; stage one feeds stage two alone
  assign stable_next = (s2_reg & ~(s2_reg ^ s3_reg)) | (stable_out & (s2_reg ^ s3_reg));

  // Shift chain
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      stable_out <= '0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      stable_out <= stable_next;
    end
  end
endmodule // bdfs_sync

// >>> src/bdfs_core.sv
// Gate-drive sequencer: soft-start, lockout, blanking, overcurrent and hiccup fault logic
`timescale 1ns/10ps
module bdfs_core (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic cycle_start,
  input wire logic duty_nonzero,
  input wire logic supply_above_start,
  input wire logic supply_above_stop,
  input wire logic ss_below_shutdown,
  input wire logic ramp_reached,
  input wire logic limit_trip,
  input wire logic switch_node_high,
  input wire logic pwm_compare_end,
  input wire logic ss_above_ref,
  input wire logic overvoltage,
  input wire logic ss_cycle_done,
  output logic high_side_gate_drive,
  output logic low_side_gate_drive,
  output logic limit_sense_pulldown,
  output logic use_ss_ramp,
  output logic fault_active,
  output logic pwm_enable,
  output logic [2:0] fault_count
);
  logic [bdfs_pkg::NUM_PINS-1:0] pins_raw;
  logic [bdfs_pkg::NUM_PINS-1:0] pins;
  bdfs_pkg::bdfs_state_t state_reg, state_next;
  logic run_reg, run_next;
  logic ramp_seen_reg, ramp_good_reg;
  logic first_pulse_reg, oc_cycle_reg, ssdone_d_reg;
  logic [7:0] blank_cnt_reg;
  logic hs_next, ls_next, pd_next;
  logic [2:0] cnt_next;

  assign pins_raw = {ss_cycle_done, overvoltage, ss_above_ref, pwm_compare_end, switch_node_high,
                     limit_trip, ramp_reached, ss_below_shutdown, supply_above_stop, supply_above_start};

  bdfs_sync #(.WIDTH(bdfs_pkg::NUM_PINS)) u_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .pin_in(pins_raw),
    .stable_out(pins)
  );

  // Decoded conditions
  wire shutdown = pins[bdfs_pkg::P_SS_LOW] | ~run_next; // RULE15
  wire active = (state_reg == bdfs_pkg::ST_SOFT) | (state_reg == bdfs_pkg::ST_NORM)
                | (state_reg == bdfs_pkg::ST_OVP);
  wire pulse_start = active & cycle_start & ramp_good_reg & duty_nonzero & pwm_enable; // RULE4
  wire release_now = limit_sense_pulldown & (pins[bdfs_pkg::P_SWHI]
                     | (blank_cnt_reg >= bdfs_pkg::BLANK_CYC_W)); // RULE8
  wire oc_event = high_side_gate_drive & ~limit_sense_pulldown & pins[bdfs_pkg::P_LIMIT_SENSE_NODE]; // RULE9
  wire hs_end = high_side_gate_drive & (oc_event | pins[bdfs_pkg::P_PWMEND]); // RULE7
  wire ssdone_pulse = pins[bdfs_pkg::P_SSDONE] & ~ssdone_d_reg;
  wire count_step = active & cycle_start;
  wire [2:0] cnt_up = fault_count + 3'h1;
  wire [2:0] cnt_dn = (fault_count == bdfs_pkg::FAULT_ZERO) ? bdfs_pkg::FAULT_ZERO : fault_count - 3'h1; // RULE16

  // Lockout with hysteresis: start level sets, the lower stop level clears
  always_comb begin
    run_next = run_reg;
    if (pins[bdfs_pkg::P_START]) begin
      run_next = 1'b1; // RULE5
    end else if (!pins[bdfs_pkg::P_STOP]) begin
      run_next = 1'b0; // RULE5
    end
  end

  // Fault counter
  always_comb begin
    cnt_next = fault_count;
    if (shutdown) begin
      cnt_next = bdfs_pkg::FAULT_ZERO;
    end else if (count_step) begin
      cnt_next = (oc_cycle_reg | oc_event) ? cnt_up : cnt_dn; // RULE10
    end else if (state_reg == bdfs_pkg::ST_HICCUP && ssdone_pulse) begin
      cnt_next = cnt_dn; // RULE13
    end
  end

  // Mode sequencing
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      bdfs_pkg::ST_OFF: begin
        if (!shutdown) state_next = bdfs_pkg::ST_SOFT;
      end
      bdfs_pkg::ST_SOFT: begin
        if (pins[bdfs_pkg::P_SSREF]) state_next = bdfs_pkg::ST_NORM; // RULE6
      end
      bdfs_pkg::ST_NORM: begin
        if (pins[bdfs_pkg::P_OVP]) state_next = bdfs_pkg::ST_OVP;
      end
      bdfs_pkg::ST_OVP: begin
        if (!pins[bdfs_pkg::P_OVP]) state_next = bdfs_pkg::ST_NORM;
      end
      bdfs_pkg::ST_HICCUP: begin
        if (cnt_next == bdfs_pkg::FAULT_ZERO) state_next = bdfs_pkg::ST_SOFT; // RULE13 RULE14
      end
      default: state_next = bdfs_pkg::ST_OFF;
    endcase
    if (active && cnt_next == bdfs_pkg::FAULT_LIMIT) begin
      state_next = bdfs_pkg::ST_HICCUP; // RULE11
    end
    if (shutdown) begin
      state_next = bdfs_pkg::ST_OFF; // RULE15
    end
  end

  // Gate drives; the low side is never on while the high side is
  always_comb begin
    hs_next = high_side_gate_drive;
    pd_next = limit_sense_pulldown;
    ls_next = low_side_gate_drive;
    if (pulse_start) begin
      hs_next = 1'b1;
      pd_next = 1'b1; // RULE8
    end else if (hs_end || cycle_start) begin
      hs_next = 1'b0; // RULE7
    end
    if (release_now && !pulse_start) pd_next = 1'b0; // RULE8
    case (state_next)
      bdfs_pkg::ST_SOFT: ls_next = (first_pulse_reg | pulse_start) & ~hs_next; // RULE1
      bdfs_pkg::ST_NORM: begin
        if (cycle_start) ls_next = 1'b0; // RULE2
        else if (hs_end) ls_next = 1'b1; // RULE2
      end
      bdfs_pkg::ST_OVP: begin
        if (cycle_start) ls_next = ~pulse_start; // RULE3
        else if (hs_end || !hs_next) ls_next = 1'b1; // RULE3
      end
      default: ls_next = 1'b0;
    endcase
    if (hs_next) ls_next = 1'b0;
    if (state_next == bdfs_pkg::ST_OFF || state_next == bdfs_pkg::ST_HICCUP) begin
      hs_next = 1'b0; // RULE11 RULE12 RULE15
      ls_next = 1'b0; // RULE11 RULE12 RULE15
      pd_next = 1'b0;
    end
  end

  // Main state and output flops
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= bdfs_pkg::ST_OFF;
      run_reg <= 1'b0;
      fault_count <= bdfs_pkg::FAULT_ZERO;
      high_side_gate_drive <= 1'b0;
      low_side_gate_drive <= 1'b0;
      limit_sense_pulldown <= 1'b0;
    end else begin
      state_reg <= state_next;
      run_reg <= run_next;
      fault_count <= cnt_next;
      high_side_gate_drive <= hs_next;
      low_side_gate_drive <= ls_next;
      limit_sense_pulldown <= pd_next;
    end
  end

  // Status outputs; modulator stays disabled for the whole hiccup
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      fault_active <= 1'b0;
      pwm_enable <= 1'b0;
      use_ss_ramp <= 1'b1;
    end else begin
      fault_active <= (state_next == bdfs_pkg::ST_HICCUP); // RULE11
      pwm_enable <= (state_next == bdfs_pkg::ST_SOFT) | (state_next == bdfs_pkg::ST_NORM)
                    | (state_next == bdfs_pkg::ST_OVP); // RULE12
      use_ss_ramp <= (state_next == bdfs_pkg::ST_SOFT) & ~pins[bdfs_pkg::P_SSREF]; // RULE6
    end
  end

  // Ramp amplitude check: seen during one cycle qualifies the start one boundary after the one that ends it
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ramp_seen_reg <= 1'b0;
      ramp_good_reg <= 1'b0;
    end else if (cycle_start) begin
      ramp_good_reg <= ramp_seen_reg | pins[bdfs_pkg::P_RAMP]; // RULE4
      ramp_seen_reg <= 1'b0;
    end else if (pins[bdfs_pkg::P_RAMP]) begin
      ramp_seen_reg <= 1'b1;
    end
  end

  // Per-cycle bookkeeping: blanking timer, overcurrent flag, first pulse, edge detect
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      blank_cnt_reg <= 8'h00;
      oc_cycle_reg <= 1'b0;
      first_pulse_reg <= 1'b0;
      ssdone_d_reg <= 1'b0;
    end else begin
      ssdone_d_reg <= pins[bdfs_pkg::P_SSDONE];
      blank_cnt_reg <= pd_next ? ((pulse_start) ? 8'h00 : blank_cnt_reg + 8'h01) : 8'h00;
      // A shutdown clears the count, so a stale overcurrent flag must not survive it
      oc_cycle_reg <= (count_step | shutdown) ? 1'b0 : (oc_cycle_reg | oc_event); // RULE10
      if (state_next != bdfs_pkg::ST_SOFT) first_pulse_reg <= 1'b0;
      else if (pulse_start) first_pulse_reg <= 1'b1; // RULE1
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  no_overlap_a: assert property (!(high_side_gate_drive && low_side_gate_drive))
    else $error("both gate drives on"); // RULE1
  soft_ls_hold_a: assert property (state_reg == bdfs_pkg::ST_SOFT && !first_pulse_reg |-> !low_side_gate_drive)
    else $error("low side on before first pulse"); // RULE1
  norm_cycle_off_a: assert property (state_reg == bdfs_pkg::ST_NORM && state_next == bdfs_pkg::ST_NORM
    && cycle_start |=> !low_side_gate_drive) else $error("low side not off at cycle start"); // RULE2
  ovp_ls_on_a: assert property (state_reg == bdfs_pkg::ST_OVP && $past(state_reg) == bdfs_pkg::ST_OVP
    && !cycle_start && !high_side_gate_drive && state_next == bdfs_pkg::ST_OVP |=> low_side_gate_drive)
    else $error("low side off in overvoltage"); // RULE3
  ramp_gate_a: assert property ($rose(high_side_gate_drive) |-> $past(ramp_good_reg))
    else $error("pulse without ramp amplitude"); // RULE4
  oc_end_a: assert property (oc_event |=> !high_side_gate_drive)
    else $error("pulse not ended on overcurrent"); // RULE7
  blank_sense_a: assert property ($rose(high_side_gate_drive) |-> limit_sense_pulldown)
    else $error("sense not pulled down at turn-on"); // RULE8
  blank_bound_a: assert property ($rose(limit_sense_pulldown) |-> ##[1:41] !limit_sense_pulldown)
    else $error("sense release timeout missed"); // RULE8
  blank_oc_a: assert property (high_side_gate_drive && limit_sense_pulldown && !pins[bdfs_pkg::P_PWMEND]
    && !cycle_start && state_next != bdfs_pkg::ST_OFF && state_next != bdfs_pkg::ST_HICCUP
    |=> high_side_gate_drive) else $error("pulse ended while blanked"); // RULE9
  fault_gates_a: assert property (fault_active |-> !high_side_gate_drive && !low_side_gate_drive && !pwm_enable)
    else $error("gate activity in fault"); // RULE12
  fault_enter_a: assert property (active && cnt_next == bdfs_pkg::FAULT_LIMIT && !shutdown |=> fault_active)
    else $error("fault not declared at seven"); // RULE11
  shut_low_a: assert property (pins[bdfs_pkg::P_SS_LOW] |=> !high_side_gate_drive && !low_side_gate_drive)
    else $error("drives on in shutdown"); // RULE15
  sat_zero_a: assert property (fault_count == bdfs_pkg::FAULT_ZERO && !oc_event && !oc_cycle_reg |=>
    fault_count == bdfs_pkg::FAULT_ZERO) else $error("counter went below zero"); // RULE16

  pulse_c: cover property ($rose(high_side_gate_drive));
  oc_c: cover property (oc_event);
  hiccup_c: cover property ($rose(fault_active));
  restart_c: cover property ($fell(fault_active) ##1 pwm_enable);
endmodule // bdfs_core

// >>> sim/bdfs_fet_model.sv
// Behavioural model of the external high-side and rectifier switches
`timescale 1ns/10ps
module bdfs_fet_model (
  input wire logic core_clk,
  input wire logic high_side_gate_drive,
  input wire logic low_side_gate_drive,
  input wire logic short_on,
  input wire logic sw_stuck,
  output logic switch_node_high,
  output logic limit_trip,
  output logic overlap_seen
);
  logic [1:0] rise_reg = 2'h0;
  // Switch node climbs two cycles after the high side conducts
  always_ff @(posedge core_clk) begin
    rise_reg <= {rise_reg[0], high_side_gate_drive & ~low_side_gate_drive};
  end
  // A stuck node never climbs, so only the blanking timeout can release sensing
  assign switch_node_high = rise_reg[1] & rise_reg[0] & ~sw_stuck;
  // Shorted load: drop exceeds the limit as soon as the high side is on
  assign limit_trip = short_on & high_side_gate_drive;
  // Both switches on together would short the supply
  assign overlap_seen = high_side_gate_drive & low_side_gate_drive;
endmodule // bdfs_fet_model

// >>> sim/bdfs_core_tb.sv
// Self-checking bench: sequencer driven against the switch-pair model
`timescale 1ns/10ps
module bdfs_core_tb;
  logic core_clk, nrst, cs, duty, sup_on, sup_off, ss_low, ramp, pend, ss_ref, ovp, ss_done;
  logic sw_hi, trip, overlap, short_on, sw_stuck, hs, ls, pd, ss_ramp, flt, pwm_en;
  logic [2:0] cnt;
  int miscompares, checks, seed, exp_cnt;
  bit prev_ocp;

  bdfs_core i_dut (.core_clk(core_clk), .nrst(nrst), .cycle_start(cs), .duty_nonzero(duty),
    .supply_above_start(sup_on), .supply_above_stop(sup_off), .ss_below_shutdown(ss_low),
    .ramp_reached(ramp), .limit_trip(trip), .switch_node_high(sw_hi), .pwm_compare_end(pend),
    .ss_above_ref(ss_ref), .overvoltage(ovp), .ss_cycle_done(ss_done), .high_side_gate_drive(hs),
    .low_side_gate_drive(ls), .limit_sense_pulldown(pd), .use_ss_ramp(ss_ramp), .fault_active(flt),
    .pwm_enable(pwm_en), .fault_count(cnt));
  bdfs_fet_model i_fet (.core_clk(core_clk), .high_side_gate_drive(hs), .low_side_gate_drive(ls),
    .short_on(short_on), .sw_stuck(sw_stuck), .switch_node_high(sw_hi), .limit_trip(trip),
    .overlap_seen(overlap));

  // 200 MHz clock
  initial begin
    core_clk = 1'h0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic chk(input string what, input logic [2:0] seen, input logic [2:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Both gates high at once is a shoot-through; looked at mid-cycle, away from the launching edge
  always @(negedge core_clk) begin
    if (overlap === 1'h1)
      chk("overlap", 3'h1, 3'h0);
  end

  // Bounded wait on high side or pulldown; running out ends the run
  task automatic wait_lvl(input bit use_pd, input logic v);
    int n;
    n = 0;
    while ((use_pd ? pd : hs) !== v && n < 100) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n >= 100) begin
      chk("wait", 3'(~v), 3'(v));
      close_out();
    end
  endtask

  // Cycle-start pulse; the bench counter model steps with it
  task automatic start_pulse(input logic exp_hs);
    @(posedge core_clk) cs <= 1'h1;
    @(posedge core_clk) cs <= 1'h0;
    repeat (2) @(posedge core_clk);
    #1;
    if (prev_ocp)
      exp_cnt++;
    else if (exp_cnt > 0)
      exp_cnt--;
    prev_ocp = 1'b0;
    chk("fault_count", cnt, 3'(exp_cnt));
    if (exp_cnt == 7) begin
      repeat (2) @(posedge core_clk);
      #1;
      chk("fault", {flt, hs, ls}, 3'h4);
      chk("pwm_enable", 3'(pwm_en), 3'h0);
    end else begin
      chk("hs start", 3'(hs), 3'(exp_hs));
      chk("pd start", 3'(pd), 3'(exp_hs));
      if (exp_hs)
        chk("ls start", 3'(ls), 3'h0);
    end
  endtask

  // Full switching cycle, ended by the comparator or by an overcurrent
  task automatic do_cycle(input bit ocp, input bit stuck);
    int w;
    w = 4 + ($unsigned($random(seed)) % 12);
    @(posedge core_clk) short_on <= ocp;
    sw_stuck <= stuck;
    start_pulse(1'h1);
    if (exp_cnt == 7)
      return;
    prev_ocp = ocp;
    if (stuck) begin
      repeat (30) @(posedge core_clk);
      #1;
      chk("blanked", {1'h0, hs, pd}, 3'h3);
      wait_lvl(1'b1, 1'h0);
    end
    if (!ocp) begin
      repeat (w) @(posedge core_clk);
      pend <= 1'h1;
    end
    wait_lvl(1'b0, 1'h0);
    repeat (2) @(posedge core_clk);
    #1;
    chk("ls after", 3'(ls), 3'h1);
    repeat (20) @(posedge core_clk);
    #1;
    chk("hs rest", 3'(hs), 3'h0);
    @(posedge core_clk) pend <= 1'h0;
    short_on <= 1'h0;
    sw_stuck <= 1'h0;
    repeat (20) @(posedge core_clk);
  endtask

  // Overcurrent cycles with one clean cycle among them until a fault
  task automatic run_to_fault();
    int i;
    i = 0;
    while (exp_cnt != 7 && i < 20) begin
      do_cycle(i != 2, i == 0);
      i++;
    end
  endtask

  // Seven soft-start cycles of hiccup, gates idle throughout
  task automatic hiccup();
    @(posedge core_clk) short_on <= 1'h0;
    for (int i = 0; i < 7; i++) begin
      @(posedge core_clk) ss_done <= 1'h1;
      repeat (8) @(posedge core_clk);
      ss_done <= 1'h0;
      repeat (8) @(posedge core_clk);
      #1;
      exp_cnt--;
      chk("hiccup count", cnt, 3'(exp_cnt));
      chk("hiccup gates", {1'h0, hs, ls}, 3'h0);
    end
    chk("restart", {1'h0, flt, pwm_en}, 3'h1);
  endtask

  initial begin
    seed = 12;
    exp_cnt = 0;
    {nrst, cs, duty, sup_on, sup_off, ss_low, ramp, pend, ss_ref, ovp, ss_done, short_on, sw_stuck} = 13'h0;
    repeat (16) @(posedge core_clk);
    #1;
    chk("reset outs", {ss_ramp, hs, ls}, 3'h4);
    chk("reset count", cnt, 3'h0);
    @(posedge core_clk) nrst <= 1'h1;
    sup_on <= 1'h1;
    sup_off <= 1'h1;
    duty <= 1'h1;
    repeat (60) @(posedge core_clk);
    start_pulse(1'h0);
    chk("ls first", 3'(ls), 3'h0);
    @(posedge core_clk) ramp <= 1'h1;
    repeat (60) @(posedge core_clk);
    // Ramp seen in this period only qualifies the start after the next boundary
    start_pulse(1'h0);
    repeat (2) do_cycle(1'b0, 1'b0);
    chk("ramp ref", 3'(ss_ramp), 3'h1);
    @(posedge core_clk) ss_ref <= 1'h1;
    repeat (10) @(posedge core_clk);
    #1;
    chk("ramp ref", 3'(ss_ramp), 3'h0);
    repeat (3) do_cycle(1'b0, 1'b0);
    @(posedge core_clk) ovp <= 1'h1;
    // The first start still falls before the synced overvoltage; the second starts inside it
    repeat (2) do_cycle(1'b0, 1'b0);
    @(posedge core_clk) duty <= 1'h0;
    start_pulse(1'h0);
    chk("ls ovp", 3'(ls), 3'h1);
    @(posedge core_clk) ovp <= 1'h0;
    duty <= 1'h1;
    repeat (10) @(posedge core_clk);
    run_to_fault();
    hiccup();
    run_to_fault();
    hiccup();
    repeat (3) do_cycle(1'b1, 1'b0);
    @(posedge core_clk) ss_low <= 1'h1;
    repeat (10) @(posedge core_clk);
    #1;
    chk("shutdown", {1'h0, hs, ls}, 3'h0);
    chk("shutdown count", cnt, 3'h0);
    exp_cnt = 0;
    prev_ocp = 1'b0;
    @(posedge core_clk) ss_low <= 1'h0;
    repeat (10) @(posedge core_clk);
    do_cycle(1'b0, 1'b0);
    @(posedge core_clk) sup_on <= 1'h0;
    repeat (10) @(posedge core_clk);
    do_cycle(1'b0, 1'b0);
    @(posedge core_clk) sup_off <= 1'h0;
    repeat (10) @(posedge core_clk);
    start_pulse(1'h0);
    chk("pwm off", 3'(pwm_en), 3'h0);
    close_out();
  end
endmodule // bdfs_core_tb
